// ### rtl/crtcv_pkg.sv
// Package: index map, reset values and carrier types of the CRT vertical and cursor block
package crtcv_pkg;

   // ------------------------------------------------------------
   // Register indices on the indexed data port
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CURSOR_END_SKEW = 8'h0b;
   localparam logic [7:0] IDX_SCREEN_START_HIGH = 8'h0c;
   localparam logic [7:0] IDX_SCREEN_START_LOW = 8'h0d;
   localparam logic [7:0] IDX_CURSOR_POSITION_HIGH = 8'h0e;
   localparam logic [7:0] IDX_CURSOR_POSITION_LOW = 8'h0f;
   localparam logic [7:0] IDX_VSYNC_START_LOW = 8'h10;
   localparam logic [7:0] IDX_VSYNC_END_CONTROL = 8'h11;
   localparam logic [7:0] IDX_ACTIVE_FRAME_END_LOW = 8'h12;
   localparam logic [7:0] IDX_ROW_PITCH_OFFSET = 8'h13;
   localparam logic [7:0] IDX_UNDERLINE_DWORD = 8'h14;
   localparam logic [7:0] IDX_VBLANK_START_LOW = 8'h15;
   localparam logic [7:0] IDX_VBLANK_END = 8'h16;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SKEW_LSB = 5;
   localparam int WPROT_BIT = 7;
   localparam int REFSEL_BIT = 6;
   localparam int IRQ_DIS_BIT = 5;
   localparam int IRQ_CLR_BIT = 4;
   localparam int DWORD_BIT = 6;
   localparam int CNT4_BIT = 5;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] IDX_RESET = 8'h00;
   localparam logic [2:0] REFRESH_NORMAL = 3'h3;
   localparam logic [2:0] REFRESH_SLOW = 3'h5;
   localparam logic [1:0] CNT4_LAST = 2'h3;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   // Bits held in the overflow and maximum scan line registers elsewhere
   typedef struct packed {
      logic [1:0] vsync_start_hi;
      logic [1:0] frame_end_hi;
      logic [1:0] vblank_start_hi;
   } crtcv_overflow_t;

   // Bits of the extension lock address register used here
   typedef struct packed {
      logic       lock_vertical;
      logic [1:0] address_ext;
   } crtcv_extlock_t;

   // Raster position from the horizontal and row counters
   typedef struct packed {
      logic       line_start;
      logic       frame_start;
      logic       row_last;
      logic       hdisp;
      logic [9:0] scan_line;
      logic [4:0] row_scan;
   } crtcv_raster_t;

   typedef enum logic [2:0] {
      AM_BYTE = 3'b001,
      AM_WORD = 3'b010,
      AM_DWORD = 3'b100
   } crtcv_amode_t;

endpackage

// ### rtl/crtcv_top.sv
// Module: cursor, start address, vertical compare and address counter of the CRT controller
//
// Function
// - Cursor delayed right by 0..3 character clocks from the skew field.
// - Cursor ends at the end row; none when end is below start.
// - Screen start address is 16 bits from high and low byte registers.
// - Two extension register bits widen the start address to 18 bits.
// - Legacy mode forces start high bits 7 and 6 to zero.
// - Cursor location 16 bits, extended to 18; legacy uses six high bits.
// - Vertical retrace start is ten bits, bits 8 and 9 from overflow.
// - Legacy reads of retrace start and end return light pen bits.
// - Write-protect bit guards indices 00..07 except the line compare bit.
// - Three refresh cycles per line, five when refresh select is set.
// - Retrace interrupt enable bit is active low.
// - Clear bit at zero resets interrupt flop; one re-arms it.
// - Vertical sync ends when low four line bits match end value.
// - Active frame ends at a ten-bit line value, high bits from overflow.
// - Next row start is current plus K times offset, K two or four.
// - Doubleword bit selects doubleword addressing, else byte or word.
// - Count-by-four clocks the address counter every fourth character clock.
// - Underline shown on the row given by the five-bit field.
// - Vertical blank starts at ten-bit value, bits from overflow and max scan.
// - Vertical blank ends at an eight-bit compare value.
// - Lock bit at one blocks writes to indices 10,11,12,15 and 16.
// - Cursor begins at the start row; none when start exceeds end.
`timescale 1ns/100ps
`default_nettype none

module crtcv_top
   import crtcv_pkg::*;
#(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Indexed register port
   input wire logic index_we,
   input wire logic data_we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // Settings held in neighbouring registers
   input wire crtcv_overflow_t overflow,
   input wire crtcv_extlock_t extlock,
   input wire logic legacy_mode,
   input wire logic word_mode,
   input wire logic [4:0] cursor_start,
   input wire logic cursor_off,
   input wire logic [13:0] light_pen,
   // Raster position
   input wire crtcv_raster_t raster,
   // Display outputs
   output logic [ADDR_W-1:0] mem_addr,
   output logic cursor_out,
   output logic underline_out,
   output logic vsync_out,
   output logic vblank_out,
   output logic vdisp_en,
   output logic refresh_req,
   output logic vretrace_irq,
   output logic low_write_protect
);

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0] index_q;
   logic [7:0] cur_end_q;
   logic [7:0] start_hi_q;
   logic [7:0] start_lo_q;
   logic [7:0] cur_hi_q;
   logic [7:0] cur_lo_q;
   logic [7:0] vs_start_q;
   logic [7:0] vs_end_q;
   logic [7:0] frame_end_q;
   logic [7:0] offset_q;
   logic [7:0] uline_q;
   logic [7:0] vb_start_q;
   logic [7:0] vb_end_q;
   logic [7:0] rdata_q;
   logic locked_idx;

   // Lock covers the vertical compare group only
   always_comb begin
      case (index_q)
         IDX_VSYNC_START_LOW, IDX_VSYNC_END_CONTROL, IDX_ACTIVE_FRAME_END_LOW,
         IDX_VBLANK_START_LOW, IDX_VBLANK_END: locked_idx = extlock.lock_vertical;
         default: locked_idx = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         index_q <= IDX_RESET;
      end else if (index_we) begin
         index_q <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cur_end_q <= REG_RESET;
         start_hi_q <= REG_RESET;
         start_lo_q <= REG_RESET;
         cur_hi_q <= REG_RESET;
         cur_lo_q <= REG_RESET;
         vs_start_q <= REG_RESET;
         vs_end_q <= REG_RESET;
         frame_end_q <= REG_RESET;
         offset_q <= REG_RESET;
         uline_q <= REG_RESET;
         vb_start_q <= REG_RESET;
         vb_end_q <= REG_RESET;
      end else if (data_we && !locked_idx) begin
         case (index_q)
            IDX_CURSOR_END_SKEW: cur_end_q <= wdata;
            IDX_SCREEN_START_HIGH: start_hi_q <= wdata;
            IDX_SCREEN_START_LOW: start_lo_q <= wdata;
            IDX_CURSOR_POSITION_HIGH: cur_hi_q <= wdata;
            IDX_CURSOR_POSITION_LOW: cur_lo_q <= wdata;
            IDX_VSYNC_START_LOW: vs_start_q <= wdata;
            IDX_VSYNC_END_CONTROL: vs_end_q <= wdata;
            IDX_ACTIVE_FRAME_END_LOW: frame_end_q <= wdata;
            IDX_ROW_PITCH_OFFSET: offset_q <= wdata;
            IDX_UNDERLINE_DWORD: uline_q <= wdata;
            IDX_VBLANK_START_LOW: vb_start_q <= wdata;
            IDX_VBLANK_END: vb_end_q <= wdata;
            default: ;
         endcase
      end
   end

   // Read data is registered; light pen replaces the retrace pair in legacy mode
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_q <= REG_RESET;
      end else begin
         case (index_q)
            IDX_CURSOR_END_SKEW: rdata_q <= cur_end_q;
            IDX_SCREEN_START_HIGH: rdata_q <= start_hi_q;
            IDX_SCREEN_START_LOW: rdata_q <= start_lo_q;
            IDX_CURSOR_POSITION_HIGH: rdata_q <= cur_hi_q;
            IDX_CURSOR_POSITION_LOW: rdata_q <= cur_lo_q;
            IDX_VSYNC_START_LOW: rdata_q <= legacy_mode ? {2'h0, light_pen[13:8]} : vs_start_q;
            IDX_VSYNC_END_CONTROL: rdata_q <= legacy_mode ? light_pen[7:0] : vs_end_q;
            IDX_ACTIVE_FRAME_END_LOW: rdata_q <= frame_end_q;
            IDX_ROW_PITCH_OFFSET: rdata_q <= offset_q;
            IDX_UNDERLINE_DWORD: rdata_q <= uline_q;
            IDX_VBLANK_START_LOW: rdata_q <= vb_start_q;
            IDX_VBLANK_END: rdata_q <= vb_end_q;
            default: rdata_q <= REG_RESET;
         endcase
      end
   end

   assign rdata = rdata_q;
   // The guarded low registers live elsewhere; they honour this level
   assign low_write_protect = vs_end_q[WPROT_BIT];

   // ------------------------------------------------------------
   // Derived addresses and compare values
   // ------------------------------------------------------------
   logic [17:0] screen_start;
   logic [17:0] cursor_loc;
   logic [9:0] vs_start10;
   logic [9:0] frame_end10;
   logic [9:0] vb_start10;
   crtcv_amode_t amode;

   // Legacy mode drops the top two high-byte bits of both addresses
   function automatic logic [7:0] hi_eff(input logic [7:0] hi, input logic legacy);
      hi_eff = legacy ? {2'h0, hi[5:0]} : hi;
   endfunction

   assign screen_start = {extlock.address_ext, hi_eff(start_hi_q, legacy_mode), start_lo_q};
   assign cursor_loc = {extlock.address_ext, hi_eff(cur_hi_q, legacy_mode), cur_lo_q};
   assign vs_start10 = {overflow.vsync_start_hi, vs_start_q};
   assign frame_end10 = {overflow.frame_end_hi, frame_end_q};
   assign vb_start10 = {overflow.vblank_start_hi, vb_start_q};

   always_comb begin
      if (uline_q[DWORD_BIT]) begin
         amode = AM_DWORD;
      end else if (word_mode) begin
         amode = AM_WORD;
      end else begin
         amode = AM_BYTE;
      end
   end

   // ------------------------------------------------------------
   // Memory address counter
   // ------------------------------------------------------------
   logic [17:0] row_start_q;
   logic [17:0] ma_q;
   logic [1:0] div4_q;
   logic ma_tick;
   logic [17:0] row_step;

   // Pitch step in the linear counter space
   assign row_step = (amode == AM_BYTE) ? {9'h000, offset_q, 1'b0} : {8'h00, offset_q, 2'h0};
   assign ma_tick = uline_q[CNT4_BIT] ? (div4_q == CNT4_LAST) : 1'b1;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         div4_q <= 2'h0;
      end else if (raster.line_start) begin
         div4_q <= 2'h0;
      end else if (raster.hdisp) begin
         div4_q <= div4_q + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         row_start_q <= 18'h00000;
      end else if (raster.frame_start) begin
         row_start_q <= screen_start;
      end else if (raster.row_last) begin
         row_start_q <= row_start_q + row_step;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ma_q <= 18'h00000;
      end else if (raster.line_start) begin
         ma_q <= raster.frame_start ? screen_start : row_start_q;
      end else if (raster.hdisp && ma_tick) begin
         ma_q <= ma_q + 18'h00001;
      end
   end

   // Rotate within the low 16 bits; upper extension bits pass straight through
   function automatic logic [17:0] addr_map(input logic [17:0] a, input crtcv_amode_t m);
      case (m)
         AM_WORD: addr_map = {a[17:16], a[14:0], a[15]};
         AM_DWORD: addr_map = {a[17:16], a[13:0], a[15:14]};
         default: addr_map = a;
      endcase
   endfunction

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mem_addr <= '0;
      end else begin
         mem_addr <= ADDR_W'(addr_map(ma_q, amode));
      end
   end

   // ------------------------------------------------------------
   // Cursor and underline
   // ------------------------------------------------------------
   logic cursor_raw;
   logic [2:0] skew_q;
   logic [1:0] skew_sel;

   assign cursor_raw = !cursor_off && raster.hdisp && (ma_q == cursor_loc)
      && (cursor_start <= cur_end_q[4:0])
      && (raster.row_scan >= cursor_start)
      && (raster.row_scan <= cur_end_q[4:0]);
   assign skew_sel = cur_end_q[SKEW_LSB+1:SKEW_LSB];

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         skew_q <= 3'h0;
      end else begin
         skew_q <= {skew_q[1:0], cursor_raw};
      end
   end

   // Skew tap chosen from the delay line
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cursor_out <= 1'b0;
      end else begin
         case (skew_sel)
            2'h0: cursor_out <= cursor_raw;
            2'h1: cursor_out <= skew_q[0];
            2'h2: cursor_out <= skew_q[1];
            default: cursor_out <= skew_q[2];
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         underline_out <= 1'b0;
      end else begin
         underline_out <= raster.hdisp && (raster.row_scan == uline_q[4:0]);
      end
   end

   // ------------------------------------------------------------
   // Vertical sync, blank and display enable
   // ------------------------------------------------------------
   logic vs_begin;

   assign vs_begin = raster.line_start && (raster.scan_line == vs_start10) && !vsync_out;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         vsync_out <= 1'b0;
      end else if (vs_begin) begin
         vsync_out <= 1'b1;
      end else if (raster.line_start && raster.scan_line[3:0] == vs_end_q[3:0]) begin
         vsync_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         vblank_out <= 1'b0;
      end else if (raster.line_start && raster.scan_line == vb_start10) begin
         vblank_out <= 1'b1;
      end else if (raster.line_start && raster.scan_line[7:0] == vb_end_q) begin
         vblank_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         vdisp_en <= 1'b0;
      end else if (raster.line_start) begin
         vdisp_en <= (raster.scan_line <= frame_end10);
      end
   end

   // ------------------------------------------------------------
   // Retrace interrupt
   // ------------------------------------------------------------
   // While the clear bit is zero the flop is held reset and retrace is ignored
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         vretrace_irq <= 1'b0;
      end else if (!vs_end_q[IRQ_CLR_BIT]) begin
         vretrace_irq <= 1'b0;
      end else if (vs_begin && !vs_end_q[IRQ_DIS_BIT]) begin
         vretrace_irq <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Refresh burst
   // ------------------------------------------------------------
   logic [2:0] refresh_left_q;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         refresh_left_q <= 3'h0;
      end else if (raster.line_start) begin
         refresh_left_q <= vs_end_q[REFSEL_BIT] ? REFRESH_SLOW : REFRESH_NORMAL;
      end else if (refresh_left_q != 3'h0) begin
         refresh_left_q <= refresh_left_q - 3'h1;
      end
   end

   assign refresh_req = (refresh_left_q != 3'h0);

endmodule

`default_nettype wire

// ### verif/crtcv_check_assertions.sv
// Checker: port timing assertions of the CRT vertical and cursor block
`timescale 1ns/100ps
`default_nettype none
module crtcv_check
   import crtcv_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port and settings
   input wire logic index_we,
   input wire logic data_we,
   input wire logic [7:0] wdata,
   input wire crtcv_extlock_t extlock,
   input wire crtcv_raster_t raster,
   // Outputs watched
   input wire logic refresh_req,
   input wire logic vsync_out,
   input wire logic vblank_out,
   input wire logic vdisp_en,
   input wire logic vretrace_irq,
   input wire logic low_write_protect
);
   logic [7:0] idx_q;
   logic [7:0] ctl_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------
   // Shadow of the index and the retrace end control register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) idx_q <= IDX_RESET;
      else if (index_we) idx_q <= wdata;
   end
   // Same-cycle index and data writes go to the old index
   always_ff @(posedge mclk) begin
      if (!resetn) ctl_q <= REG_RESET;
      else if (data_we && idx_q == IDX_VSYNC_END_CONTROL && !extlock.lock_vertical) ctl_q <= wdata;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   sequence s_ref3;
      refresh_req [*3] ##1 !refresh_req;
   endsequence
   sequence s_ref5;
      refresh_req [*5] ##1 !refresh_req;
   endsequence
   property p_ref_normal;
      raster.line_start && !ctl_q[REFSEL_BIT] |=> s_ref3;
   endproperty
   property p_ref_slow;
      raster.line_start && ctl_q[REFSEL_BIT] |=> s_ref5;
   endproperty
   property p_wprot;
      low_write_protect == ctl_q[WPROT_BIT];
   endproperty
   property p_lock;
      data_we && extlock.lock_vertical && idx_q == IDX_VSYNC_END_CONTROL |=> $stable(low_write_protect);
   endproperty
   property p_irq_clr;
      !ctl_q[IRQ_CLR_BIT] |=> !vretrace_irq;
   endproperty
   property p_irq_dis;
      ctl_q[IRQ_DIS_BIT] && !vretrace_irq |=> !vretrace_irq;
   endproperty
   property p_irq_set;
      $rose(vsync_out) && !ctl_q[IRQ_DIS_BIT] && ctl_q[IRQ_CLR_BIT] |-> vretrace_irq;
   endproperty
   property p_irq_hold;
      vretrace_irq && ctl_q[IRQ_CLR_BIT] |=> vretrace_irq;
   endproperty
   property p_vstable;
      !raster.line_start |=> $stable({vsync_out, vblank_out, vdisp_en});
   endproperty
   property p_vsync_end;
      raster.line_start && vsync_out && raster.scan_line[3:0] == ctl_q[3:0] |=> !vsync_out;
   endproperty
   a_ref_normal: assert property (p_ref_normal) else $error("three refresh cycles expected");
   a_ref_slow: assert property (p_ref_slow) else $error("five refresh cycles expected");
   a_wprot: assert property (p_wprot) else $error("write protect level wrong");
   a_lock: assert property (p_lock) else $error("locked write took effect");
   a_irq_clr: assert property (p_irq_clr) else $error("irq not held cleared");
   a_irq_dis: assert property (p_irq_dis) else $error("disabled irq raised");
   a_irq_set: assert property (p_irq_set) else $error("irq missing at retrace");
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped while armed");
   a_vstable: assert property (p_vstable) else $error("vertical output moved off line start");
   a_vsync_end: assert property (p_vsync_end) else $error("vsync not ended at match");
endmodule
bind crtcv_top crtcv_check i_crtcv_check (
   .mclk(mclk), .resetn(resetn), .index_we(index_we), .data_we(data_we),
   .wdata(wdata), .extlock(extlock), .raster(raster), .refresh_req(refresh_req),
   .vsync_out(vsync_out), .vblank_out(vblank_out), .vdisp_en(vdisp_en),
   .vretrace_irq(vretrace_irq), .low_write_protect(low_write_protect)
);
`default_nettype wire

// ### verif/crtcv_host.sv
// Host model: drives the indexed register port of the CRT block
`timescale 1ns/100ps
`default_nettype none
module crtcv_host (
   // Clock
   input wire logic mclk,
   // Register port
   output logic index_we,
   output logic data_we,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   initial begin
      index_we = 1'b0;
      data_we = 1'b0;
      wdata = 8'h00;
   end
   // Idle data is inverted so a stale byte never looks like a valid write
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(negedge mclk);
      index_we = 1'b1;
      wdata = idx;
      @(negedge mclk);
      index_we = 1'b0;
      data_we = 1'b1;
      wdata = d;
      @(negedge mclk);
      data_we = 1'b0;
      wdata = ~d;
   endtask
   // Read data is registered: index loads on one edge, data on the next
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      @(negedge mclk);
      index_we = 1'b1;
      wdata = idx;
      @(negedge mclk);
      index_we = 1'b0;
      wdata = ~idx;
      @(negedge mclk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// ### verif/crtcv_top_bench.sv
// Testbench: register port, vertical compares and start address of the CRT block
`timescale 1ns/100ps
`default_nettype none
module crtcv_top_bench
   import crtcv_pkg::*;
;
   logic mclk, resetn, index_we, data_we, legacy_mode;
   logic [7:0] wdata, rdata, d, ctl;
   logic [13:0] light_pen;
   crtcv_overflow_t overflow;
   crtcv_extlock_t extlock;
   crtcv_raster_t raster;
   logic [17:0] mem_addr;
   logic vsync_out, vblank_out, vdisp_en, refresh_req, vretrace_irq, low_write_protect;
   logic vs, vb, vd, irq, prev;
   logic word_mode, cursor_out, underline_out;
   logic [4:0] cursor_start;
   logic [7:0] m [0:255];
   integer mismatches, cmp_count, seed, p, i, sl;
   crtcv_top i_crtcv_top (.mclk(mclk), .resetn(resetn), .index_we(index_we),
      .data_we(data_we), .wdata(wdata), .rdata(rdata), .overflow(overflow),
      .extlock(extlock), .legacy_mode(legacy_mode), .word_mode(word_mode),
      .cursor_start(cursor_start), .cursor_off(1'b0), .light_pen(light_pen), .raster(raster),
      .mem_addr(mem_addr), .cursor_out(cursor_out), .underline_out(underline_out),
      .vsync_out(vsync_out),
      .vblank_out(vblank_out), .vdisp_en(vdisp_en), .refresh_req(refresh_req),
      .vretrace_irq(vretrace_irq), .low_write_protect(low_write_protect));
   crtcv_host i_crtcv_host (.mclk(mclk), .index_we(index_we), .data_we(data_we),
      .wdata(wdata), .rdata(rdata));
   always #50 mclk = ~mclk;
   // ------------------------------------------------------------
   // Compare, raster and report helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_addr(input logic [17:0] exp);
      cmp_count++;
      if (mem_addr !== exp) begin
         mismatches++;
         $display("FAIL %0t address %h exp %h", $time, mem_addr, exp);
      end
   endtask
   // Lines are spaced so the longest refresh burst ends first
   task automatic line(input integer s, input logic fs, input logic rl);
      @(negedge mclk);
      raster.scan_line = s[9:0];
      raster.line_start = 1'b1;
      raster.frame_start = fs;
      raster.row_last = rl;
      @(negedge mclk);
      raster.line_start = 1'b0;
      raster.frame_start = 1'b0;
      raster.row_last = 1'b0;
      repeat (7) @(negedge mclk);
   endtask
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      summarize();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      legacy_mode = 1'b0;
      word_mode = 1'b0;
      cursor_start = 5'h00;
      light_pen = 14'h0000;
      overflow = '0;
      extlock = '0;
      raster = '0;
      seed = 32'hc5fe;
      mismatches = 0;
      cmp_count = 0;
      vs = 1'b0;
      vb = 1'b0;
      irq = 1'b0;
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      for (i = 0; i < 256; i++) m[i] = REG_RESET;
      // Reset values and random writes, a locked pass, then an unlocked pass
      for (p = 0; p < 3; p++) begin
         extlock.lock_vertical = (p == 1);
         for (i = 11; i <= 22; i++) begin
            i_crtcv_host.rd(i[7:0], d);
            chk(d, m[i]);
            d = 8'($random(seed));
            i_crtcv_host.wr(i[7:0], d);
            if (!(p == 1 && (i == 16 || i == 17 || i == 18 || i == 21 || i == 22))) m[i] = d;
         end
      end
      i_crtcv_host.rd(8'h20, d);
      chk(d, 8'h00);
      legacy_mode = 1'b1;
      light_pen = 14'($random(seed));
      i_crtcv_host.rd(IDX_VSYNC_START_LOW, d);
      chk(d & 8'h3f, {2'b00, light_pen[13:8]});
      i_crtcv_host.rd(IDX_VSYNC_END_CONTROL, d);
      chk(d, light_pen[7:0]);
      legacy_mode = 1'b0;
      // Vertical compares: low lines, high lines with overflow bits, irq disabled
      for (p = 0; p < 3; p++) begin
         ctl = {1'b0, p[0], p == 2, 1'b1, 4'h8};
         overflow = crtcv_overflow_t'({3{1'b0, p[0]}});
         i_crtcv_host.wr(IDX_VSYNC_START_LOW, 8'h05);
         i_crtcv_host.wr(IDX_ACTIVE_FRAME_END_LOW, 8'h04);
         i_crtcv_host.wr(IDX_VBLANK_START_LOW, 8'h03);
         i_crtcv_host.wr(IDX_VBLANK_END, 8'h0a);
         i_crtcv_host.wr(IDX_VSYNC_END_CONTROL, ctl & 8'hef);
         irq = 1'b0;
         i_crtcv_host.wr(IDX_VSYNC_END_CONTROL, ctl);
         chk({7'h00, vretrace_irq}, 8'h00);
         for (i = 0; i < 16; i++) begin
            sl = p[0] * 256 + i;
            line(sl, 1'b0, 1'b0);
            prev = vs;
            if (sl == p[0] * 256 + 5) vs = 1'b1;
            else if ((sl & 15) == 8) vs = 1'b0;
            if (vs && !prev && !ctl[5] && ctl[4]) irq = 1'b1;
            if (sl == p[0] * 256 + 3) vb = 1'b1;
            else if ((sl & 255) == 10) vb = 1'b0;
            vd = (sl <= p[0] * 256 + 4);
            chk({4'h0, vsync_out, vblank_out, vdisp_en, vretrace_irq}, {4'h0, vs, vb, vd, irq});
         end
      end
      // Start address with extension bits and masked high bits, then one row step
      legacy_mode = 1'b1;
      extlock.address_ext = 2'b10;
      i_crtcv_host.wr(IDX_SCREEN_START_HIGH, 8'hff);
      i_crtcv_host.wr(IDX_SCREEN_START_LOW, 8'h34);
      i_crtcv_host.wr(IDX_ROW_PITCH_OFFSET, 8'h21);
      i_crtcv_host.wr(IDX_UNDERLINE_DWORD, 8'h00);
      line(0, 1'b1, 1'b0);
      cmp_addr(18'h23f34);
      line(1, 1'b0, 1'b1);
      // The stepped row start reaches the counter at the next line start
      line(2, 1'b0, 1'b0);
      cmp_addr(18'h23f34 + 18'h00042);
      // Cursor two places after the start, masked high byte; skew 0..3, then end below start
      cursor_start = 5'h02;
      raster.row_scan = 5'h03;
      i_crtcv_host.wr(IDX_CURSOR_POSITION_HIGH, 8'hff);
      i_crtcv_host.wr(IDX_CURSOR_POSITION_LOW, 8'h36);
      for (p = 0; p < 5; p++) begin
         i_crtcv_host.wr(IDX_CURSOR_END_SKEW, {1'b0, p[1:0], (p == 4) ? 5'h01 : 5'h04});
         i_crtcv_host.wr(IDX_UNDERLINE_DWORD, {3'h0, 4'h1, p[0]});
         line(0, 1'b1, 1'b0);
         raster.hdisp = 1'b1;
         sl = 0;
         for (i = 1; i <= 8; i++) begin
            @(negedge mclk);
            if (cursor_out) sl = (sl == 0) ? i : 99;
            chk({7'h00, underline_out}, {7'h00, p[0]});
         end
         raster.hdisp = 1'b0;
         // Two clocks to the location, one cursor output register stage, then the skew
         chk(sl[7:0], (p == 4) ? 8'h00 : 8'(3 + p));
      end
      // Word mode: step of four times the offset, counter rotated by one
      word_mode = 1'b1;
      line(0, 1'b1, 1'b0);
      line(1, 1'b0, 1'b1);
      line(2, 1'b0, 1'b0);
      cmp_addr(18'h27f70);
      summarize();
   end
endmodule
`default_nettype wire
